// file: hdl/touch_scan_regs.vh
`ifndef TOUCH_SCAN_REGS_VH
`define TOUCH_SCAN_REGS_VH

// switch pattern bit positions on panel_drive_pins
`define SW_ONE_BIT 0
`define SW_TWO_BIT 1
`define SW_THREE_BIT 2
`define SW_FOUR_BIT 3

// switch patterns, bit set = switch conducting
`define PAT_IDLE 4'h1
`define PAT_X 4'hA
`define PAT_Y 4'h5

// analog channel numbers
`define X_SENSE_CHANNEL 3'h1
`define Y_SENSE_CHANNEL 3'h0

// sample width
`define COORD_W 10

// settle counter width, and a settle count constant left unused; settle_r resets to zero
`define SETTLE_W 16
`define SETTLE_RESET 16'h0040

`endif

// file: hdl/two_flop_sync.v
`timescale 1ns/1ps
`default_nettype none
module two_flop_sync (
   // clock and reset
   input wire clk_sys,
   input wire rst_n,
   // level in and out
   input wire d,
   output reg q
);
   reg meta_r;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= 1'b1;
         q <= 1'b1;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule
`default_nettype wire

// file: hdl/resistive_touch_scan_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "touch_scan_regs.vh"
// Function
// - In idle, switch one conducts and switches two, three and four are off.
// - A low touch interrupt level starts a coordinate scan.
// - The X phase turns switches two and four on and one and three off.
// - The X phase converts the X sense channel and captures the result.
// - After the X sample, switches two and four go off and one and three on for Y.
// - The Y phase converts the Y sense channel and captures the result.
// - After both samples the idle pattern returns and the next touch is awaited.
// - The panel uses one interrupt input and four drive output lines.
// - Each coordinate is held as a 10-bit conversion result.
module resistive_touch_scan_sequencer (
   // clock and reset
   input wire clk_sys,
   input wire reset_n,
   // touch panel
   input wire touch_irq_in,
   output reg [3:0] panel_drive_pins,
   // converter
   output reg adc_start,
   output reg [2:0] adc_channel,
   input wire adc_done,
   input wire [`COORD_W-1:0] adc_result,
   // configuration
   input wire [`SETTLE_W-1:0] settle_count,
   // results
   output reg [`COORD_W-1:0] x_coord,
   output reg [`COORD_W-1:0] y_coord,
   output reg coord_valid,
   output reg scan_busy
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_X_SETTLE = 3'h1;
   localparam [2:0] ST_X_CONV = 3'h2;
   localparam [2:0] ST_Y_SETTLE = 3'h3;
   localparam [2:0] ST_Y_CONV = 3'h4;

   reg rst_meta_r;
   reg rst_sync_r;
   wire rst_n;
   wire irq_sync;
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [`SETTLE_W-1:0] settle_r;
   reg [`SETTLE_W-1:0] settle_nxt;
   reg [3:0] pins_nxt;
   reg start_nxt;
   reg [2:0] channel_nxt;
   reg [`COORD_W-1:0] x_nxt;
   reg [`COORD_W-1:0] y_nxt;
   reg valid_nxt;
   reg busy_nxt;
   wire settle_zero;
   wire touch_seen;

   // reset enters asynchronously, releases through two flops
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end
   assign rst_n = rst_sync_r;

   // the irq pin is asynchronous to clk_sys
   two_flop_sync u_irq_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .d(touch_irq_in),
      .q(irq_sync)
   );

   assign settle_zero = (settle_r == {`SETTLE_W{1'b0}});
   assign touch_seen = !irq_sync;

   // every register except adc_start and coord_valid holds unless a branch below moves it
   always @* begin
      state_nxt = state_r;
      settle_nxt = settle_r;
      pins_nxt = panel_drive_pins;
      start_nxt = 1'b0;
      channel_nxt = adc_channel;
      x_nxt = x_coord;
      y_nxt = y_coord;
      valid_nxt = 1'b0;
      busy_nxt = scan_busy;
      case (state_r)
         ST_IDLE: begin
            pins_nxt = `PAT_IDLE;
            busy_nxt = 1'b0;
            if (touch_seen) begin
               pins_nxt = `PAT_X;
               settle_nxt = settle_count;
               busy_nxt = 1'b1;
               state_nxt = ST_X_SETTLE;
            end
         end
         ST_X_SETTLE: begin
            // the panel is an RC load; converting before it settles gives skewed reads
            if (settle_zero) begin
               channel_nxt = `X_SENSE_CHANNEL;
               start_nxt = 1'b1;
               state_nxt = ST_X_CONV;
            end else begin
               settle_nxt = settle_r - 1'b1;
            end
         end
         ST_X_CONV: begin
            // irq is ignored in every scan state
            if (adc_done) begin
               x_nxt = adc_result;
               pins_nxt = `PAT_Y;
               settle_nxt = settle_count;
               state_nxt = ST_Y_SETTLE;
            end
         end
         ST_Y_SETTLE: begin
            if (settle_zero) begin
               channel_nxt = `Y_SENSE_CHANNEL;
               start_nxt = 1'b1;
               state_nxt = ST_Y_CONV;
            end else begin
               settle_nxt = settle_r - 1'b1;
            end
         end
         ST_Y_CONV: begin
            if (adc_done) begin
               y_nxt = adc_result;
               pins_nxt = `PAT_IDLE;
               valid_nxt = 1'b1;
               busy_nxt = 1'b0;
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            pins_nxt = `PAT_IDLE;
            busy_nxt = 1'b0;
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         settle_r <= {`SETTLE_W{1'b0}};
      end else begin
         settle_r <= settle_nxt;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         panel_drive_pins <= `PAT_IDLE;
      end else begin
         panel_drive_pins <= pins_nxt;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         adc_start <= 1'b0;
      end else begin
         adc_start <= start_nxt;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         adc_channel <= `X_SENSE_CHANNEL;
      end else begin
         adc_channel <= channel_nxt;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         x_coord <= {`COORD_W{1'b0}};
      end else begin
         x_coord <= x_nxt;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         y_coord <= {`COORD_W{1'b0}};
      end else begin
         y_coord <= y_nxt;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         coord_valid <= 1'b0;
      end else begin
         coord_valid <= valid_nxt;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         scan_busy <= 1'b0;
      end else begin
         scan_busy <= busy_nxt;
      end
   end
endmodule
`default_nettype wire

// file: testbench/scan_props_properties.sv
`timescale 1ns/1ps
`default_nettype none
module scan_props (
   input wire logic clk_sys, reset_n, touch_irq_in, adc_start, adc_done, coord_valid, scan_busy,
   input wire logic [3:0] panel_drive_pins,
   input wire logic [2:0] adc_channel,
   input wire logic [9:0] adc_result, x_coord, y_coord,
   input wire logic [15:0] settle_count
);
   logic [15:0] cnt_r = 16'h0000;
   logic [3:0] pat_r = 4'h1;
   // counts cycles since the switch pattern last changed
   always @(posedge clk_sys) begin
      pat_r <= panel_drive_pins;
      cnt_r <= (panel_drive_pins != pat_r) ? 16'h0000 : cnt_r + 16'h0001;
   end
   sequence x_done; adc_done && panel_drive_pins == 4'hA; endsequence
   sequence y_done; adc_done && panel_drive_pins == 4'h5; endsequence
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   a_idle_pattern: assert property (!scan_busy |-> panel_drive_pins == 4'h1)
      else $error("idle pattern");
   a_touch_start: assert property ((!touch_irq_in && !scan_busy) [*4] |=> scan_busy)
      else $error("no scan");
   a_x_pattern: assert property ($rose(scan_busy) |-> panel_drive_pins == 4'hA)
      else $error("x pattern");
   a_sense_channel: assert property (adc_start |-> adc_channel == {2'b00, panel_drive_pins[1]})
      else $error("channel");
   a_x_capture: assert property (x_done |=> panel_drive_pins == 4'h5 && x_coord == $past(adc_result))
      else $error("x capture");
   a_y_capture: assert property (y_done |=> coord_valid && panel_drive_pins == 4'h1 && y_coord == $past(adc_result))
      else $error("y capture");
   a_settle_wait: assert property (adc_start |-> cnt_r == settle_count)
      else $error("settle");
   a_valid_pulse: assert property (coord_valid |=> !coord_valid)
      else $error("valid pulse");
endmodule
bind resistive_touch_scan_sequencer scan_props u_props (.clk_sys(clk_sys), .reset_n(reset_n),
   .touch_irq_in(touch_irq_in), .adc_start(adc_start), .adc_done(adc_done),
   .coord_valid(coord_valid), .scan_busy(scan_busy), .panel_drive_pins(panel_drive_pins),
   .adc_channel(adc_channel), .adc_result(adc_result), .x_coord(x_coord), .y_coord(y_coord),
   .settle_count(settle_count));
`default_nettype wire

// file: testbench/touch_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module touch_adc_model (
   input wire logic clk_sys, adc_start,
   input wire logic [2:0] adc_channel,
   input wire logic [9:0] x_val, y_val,
   input wire logic [3:0] lat,
   output logic adc_done = 1'b0,
   output logic [9:0] adc_result = 10'h000
);
   // result flips once invalid so a stale capture cannot match
   always @(posedge clk_sys) if (adc_start) begin
      repeat (lat) @(posedge clk_sys);
      adc_done <= 1'b1;
      adc_result <= (adc_channel == 3'h1) ? x_val : y_val;
      @(posedge clk_sys);
      {adc_done, adc_result} <= {1'b0, ~adc_result};
   end
endmodule
`default_nettype wire

// file: testbench/resistive_touch_scan_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module resistive_touch_scan_sequencer_tb;
   logic clk_sys = 0, reset_n = 0, touch_irq_in = 1, adc_start, adc_done, coord_valid, scan_busy;
   logic [15:0] settle_count = 0;
   logic [9:0] x_val = 0, y_val = 0, x_coord, y_coord, adc_result;
   logic [3:0] lat = 0, panel_drive_pins;
   logic [2:0] adc_channel;
   logic [19:0] exp_q[$];
   int error_cnt = 0, check_count = 0;
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
$display("wrong value at %0t: mismatch", $time); end end
   always #12.5 clk_sys = ~clk_sys;
   resistive_touch_scan_sequencer dut (.clk_sys(clk_sys), .reset_n(reset_n),
      .touch_irq_in(touch_irq_in), .panel_drive_pins(panel_drive_pins), .adc_start(adc_start),
      .adc_channel(adc_channel), .adc_done(adc_done), .adc_result(adc_result),
      .settle_count(settle_count), .x_coord(x_coord), .y_coord(y_coord),
      .coord_valid(coord_valid), .scan_busy(scan_busy));
   touch_adc_model adc (.clk_sys(clk_sys), .adc_start(adc_start), .adc_channel(adc_channel),
      .x_val(x_val), .y_val(y_val), .lat(lat), .adc_done(adc_done), .adc_result(adc_result));
   task report_and_stop;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task wt(input logic v);
      for (int i = 0; i < 300 && scan_busy !== v; i++) @(negedge clk_sys);
      `CHK(scan_busy, v)
   endtask
   // a held touch must give a second scan; toggling mid-scan must not
   task scan(input int hold);
      @(negedge clk_sys);
      settle_count = 16'($urandom % 4);
      lat = 4'($urandom % 5);
      {x_val, y_val} = 20'($urandom);
      touch_irq_in = 0;
      for (int k = 0; k <= hold; k++) begin
         exp_q.push_back({x_val, y_val});
         wt(1);
         if (k == hold) repeat (3) @(negedge clk_sys) touch_irq_in = ~touch_irq_in;
         wt(0);
      end
   endtask
   always @(negedge clk_sys) if (coord_valid === 1'b1) begin
      if (exp_q.size() == 0) `CHK(1'b0, 1'b1)
      else `CHK({x_coord, y_coord}, exp_q.pop_front())
   end
   initial begin
      void'($urandom(32'h35ac));
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys) reset_n = 1;
      `CHK(panel_drive_pins, 4'h1)
      repeat (4) @(negedge clk_sys);
      for (int n = 0; n < 6; n++) begin
         scan(n == 2);
         repeat (6) @(negedge clk_sys);
         `CHK(scan_busy, 1'b0)
      end
      `CHK(exp_q.size(), 0)
      report_and_stop;
   end
   initial begin
      #100us;
      error_cnt++;
      report_and_stop;
   end
endmodule
`default_nettype wire
